//--- common/tg_pkg.sv
// Shared constants for the two-oscillator tone setup block
package tg_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [9:0] IDX_CTRL = 10'h1c0; // Control: go, digit mode, clock enable
  localparam logic [9:0] IDX_A_HI = 10'h1c1; // Tone A pitch code bits 14:8
  localparam logic [9:0] IDX_A_LO = 10'h1c2; // Tone A pitch code bits 7:0
  localparam logic [9:0] IDX_B_HI = 10'h1c3; // Tone B pitch code bits 14:8
  localparam logic [9:0] IDX_B_LO = 10'h1c4; // Tone B pitch code bits 7:0
  localparam logic [9:0] IDX_A_LVL = 10'h1c5; // Tone A loudness
  localparam logic [9:0] IDX_B_LVL = 10'h1c6; // Tone B loudness
  localparam logic [9:0] IDX_ON_MS = 10'h1c7; // Present time in ms
  localparam logic [9:0] IDX_GAP_MS = 10'h1c8; // Gap time in ms
  localparam logic [9:0] IDX_COUNT = 10'h1c9; // Digit or burst count
  localparam logic [9:0] IDX_STATUS = 10'h1cf; // Sequencer state, read only
  localparam logic [9:0] IDX_DIGIT0 = 10'h1d0; // First packed digit pair
  localparam int DIGIT_PAIRS = 12; // Twelve bytes of packed digits
  localparam int MAX_COUNT = 24; // Most digits or bursts per run

  // ==========================================================================
  // Control field positions
  // ==========================================================================
  localparam int CTRL_GO_BIT = 0; // generate_go
  localparam int CTRL_DIGIT_BIT = 1; // digit_mode_select
  localparam int CTRL_CLKEN_BIT = 7; // Tone clock enable

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int PITCH_HI_W = 7; // Upper pitch field width
  localparam int COUNT_W = 5; // Count field, bits 4:0
  localparam int FREQ_W = 20; // Output frequency in 0.1 Hz units
  localparam logic [7:0] BYTE_RST = 8'h00; // Reset of every byte register

  // ==========================================================================
  // Frequency law and level law
  // ==========================================================================
  localparam logic [4:0] PITCH_DHZ_STEP = 5'h19; // 2.5 Hz step, as 25 tenths
  localparam logic [8:0] LEVEL_ZERO_DB = 9'h03f; // Code 63 is 0 dBFS
  // DTMF rows and columns in 0.1 Hz units
  localparam logic [19:0] ROW0_DHZ = 20'h01b3a; // 697 Hz
  localparam logic [19:0] ROW1_DHZ = 20'h01e14; // 770 Hz
  localparam logic [19:0] ROW2_DHZ = 20'h02148; // 852 Hz
  localparam logic [19:0] ROW3_DHZ = 20'h024c2; // 941 Hz
  localparam logic [19:0] COL0_DHZ = 20'h02f3a; // 1209 Hz
  localparam logic [19:0] COL1_DHZ = 20'h03430; // 1336 Hz
  localparam logic [19:0] COL2_DHZ = 20'h039b2; // 1477 Hz
  localparam logic [19:0] COL3_DHZ = 20'h03fca; // 1633 Hz

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40; // 25 MHz core clock
  localparam int MS_NS = 1000000; // One millisecond in ns
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS; // Cycles per millisecond

  // ==========================================================================
  // Bus answers and sequencer states
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0; // Normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, // Nothing generated
    ST_ON = 4'h2, // Tone or digit present
    ST_GAP = 4'h4, // Silence between bursts
    ST_CONT = 4'h8 // Endless tone
  } tg_state_type;

endpackage : tg_pkg

//--- testbench/test_tg_tone_seq.sv
// Self-checking bench for the tone setup block
`timescale 1ns/100ps
`define CK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t got %h", $time, g); end end
module test_tg_tone_seq;
  localparam int MS = 4; // Short millisecond keeps the run brief
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 0, s_axi_rready = 0; // Raised late so every answer must stand
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tone_clk_en, tone_a_on, tone_b_on;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [19:0] tone_a_freq_dhz, tone_b_freq_dhz, fa[$], fb[$];
  logic signed [8:0] tone_a_gain_hdb, tone_b_gain_hdb;
  logic was_on = 0;
  int error_cnt = 0, checks_done = 0, on_cyc = 0, rises = 0;
  // Row and column per digit code, two bits each, code 0 lowest
  logic [31:0] row_map = 32'h93fa9503, col_map = 32'hfe192493;
  logic [19:0] rf[4] = '{tg_pkg::ROW0_DHZ, tg_pkg::ROW1_DHZ, tg_pkg::ROW2_DHZ, tg_pkg::ROW3_DHZ};
  logic [19:0] cf[4] = '{tg_pkg::COL0_DHZ, tg_pkg::COL1_DHZ, tg_pkg::COL2_DHZ, tg_pkg::COL3_DHZ};
  tg_tone_seq #(.MS_CYCLES(MS)) i_tg_tone_seq (.*);
  always #20 aclk = ~aclk;
  // Count present cycles; log both frequencies at each burst start
  always @(posedge aclk)
  begin
    was_on <= tone_a_on;
    if (tone_a_on) on_cyc++;
    if (tone_a_on && !was_on)
    begin
      rises++;
      fa.push_back(tone_a_freq_dhz);
      fb.push_back(tone_b_freq_dhz);
    end
  end
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    fork
      begin @(posedge aclk iff s_axi_awready); s_axi_awvalid <= 0; end
      begin @(posedge aclk iff s_axi_wready); s_axi_wvalid <= 0; end
    join
    @(posedge aclk iff s_axi_bvalid);
    s_axi_bready <= 1;
    @(posedge aclk iff s_axi_bvalid);
    s_axi_bready <= 0;
    `CK(s_axi_bresp, er)
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [7:0] ex, input logic [1:0] er = 2'h0);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    @(posedge aclk iff s_axi_arready);
    s_axi_arvalid <= 0;
    @(posedge aclk iff s_axi_rvalid);
    s_axi_rready <= 1;
    @(posedge aclk iff s_axi_rvalid);
    s_axi_rready <= 0;
    `CK(s_axi_rdata, {24'h0, ex})
    `CK(s_axi_rresp, er)
  endtask : rd
  task automatic t_regs;
    rd(tg_pkg::IDX_A_HI, 8'h00);
    wr(tg_pkg::IDX_A_HI, 8'h06);
    wr(tg_pkg::IDX_A_LO, 8'h40);
    wr(tg_pkg::IDX_A_LVL, 8'h4b);
    rd(tg_pkg::IDX_A_HI, 8'h06);
    rd(tg_pkg::IDX_A_LVL, 8'h4b);
    s_axi_wstrb <= 4'h0;
    wr(tg_pkg::IDX_A_LVL, 8'h11);
    s_axi_wstrb <= 4'hf;
    rd(tg_pkg::IDX_A_LVL, 8'h4b);
    rd(10'h1ff, 8'h00, tg_pkg::RESP_SLVERR);
    wr(tg_pkg::IDX_STATUS, 8'h01, tg_pkg::RESP_SLVERR);
    $display("register test done");
  endtask : t_regs
  // Two bursts; a zero gap must merge them into one tone
  task automatic t_prog(input logic [7:0] gap);
    on_cyc = 0;
    rises = 0;
    fa.delete();
    wr(tg_pkg::IDX_ON_MS, 8'h01);
    wr(tg_pkg::IDX_GAP_MS, gap);
    wr(tg_pkg::IDX_COUNT, 8'h02);
    wr(tg_pkg::IDX_CTRL, 8'h81);
    @(posedge aclk iff rises == (gap == 0 ? 1 : 2) && !tone_a_on);
    `CK(on_cyc, 2 * MS)
    `CK(rises, (gap == 0 ? 1 : 2))
    `CK(fa[0], 20'h09c40)
    `CK(tone_a_gain_hdb, 9'sh00c)
    `CK(tone_b_gain_hdb, 9'sh1c1)
    rd(tg_pkg::IDX_CTRL, 8'h80);
    $display("burst test done");
  endtask : t_prog
  // Digits 0 to 15 in bank order; pitch code A is nonzero meanwhile
  task automatic t_dtmf;
    rises = 0;
    fa.delete();
    fb.delete();
    for (int k = 0; k < 8; k++) wr(10'(tg_pkg::IDX_DIGIT0 + k), {k[2:0], 1'b0, k[2:0], 1'b1});
    wr(tg_pkg::IDX_GAP_MS, 8'h01);
    wr(tg_pkg::IDX_COUNT, 8'h10);
    wr(tg_pkg::IDX_CTRL, 8'h83);
    @(posedge aclk iff rises == 16 && !tone_a_on);
    `CK(rises, 16)
    for (int k = 0; k < 16; k++)
    begin
      `CK(fa[k], rf[row_map[2*k+:2]])
      `CK(fb[k], cf[col_map[2*k+:2]])
    end
    rd(tg_pkg::IDX_CTRL, 8'h82);
    $display("digit test done");
  endtask : t_dtmf
  task automatic t_cont;
    wr(tg_pkg::IDX_ON_MS, 8'h00);
    wr(tg_pkg::IDX_GAP_MS, 8'h00);
    wr(tg_pkg::IDX_COUNT, 8'h00);
    wr(tg_pkg::IDX_CTRL, 8'h81);
    repeat (300) @(posedge aclk);
    `CK(tone_a_on, 1'b1)
    `CK(tone_b_on, 1'b0)
    `CK(tone_clk_en, 1'b1)
    wr(tg_pkg::IDX_B_LO, 8'h01);
    repeat (3) @(posedge aclk);
    `CK(tone_b_on, 1'b1)
    `CK(tone_b_freq_dhz, 20'h00019)
    wr(tg_pkg::IDX_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    `CK(tone_a_on, 1'b0)
    `CK(tone_clk_en, 1'b0)
    $display("continuous test done");
  endtask : t_cont
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_prog(8'h01);
    t_prog(8'h00);
    t_dtmf();
    t_cont();
    report_and_stop();
  end
  // Watchdog: far beyond the several hundred cycles the tests need
  initial
  begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end
endmodule : test_tg_tone_seq

//--- testbench/tg_tone_seq_checker.sv
// Bus handshake and tone output assertions for the tone setup block
`timescale 1ns/100ps
module tg_tone_seq_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tone_clk_en,
  input wire logic tone_a_on,
  input wire logic [19:0] tone_a_freq_dhz,
  input wire logic tone_b_on,
  input wire logic [19:0] tone_b_freq_dhz
);
  // ==========================================================================
  // Assertions, all in the core clock domain
  // ==========================================================================
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_a_zero_off: assert property (tone_a_on |-> tone_a_freq_dhz != 20'h0)
    else $error("tone A sounding at zero pitch");
  a_b_zero_off: assert property (tone_b_on |-> tone_b_freq_dhz != 20'h0)
    else $error("tone B sounding at zero pitch");
  a_clk_gate: assert property (tone_a_on || tone_b_on |-> $past(tone_clk_en))
    else $error("tone without clock enable");
endmodule : tg_tone_seq_checker

bind tg_tone_seq tg_tone_seq_checker i_tg_tone_seq_checker (.*);

//--- verilog/tg_dtmf_map.sv
// Four-bit digit code to row and column frequency lookup
`timescale 1ns/100ps
module tg_dtmf_map (
  input wire logic [3:0] code,
  output logic [19:0] row_dhz,
  output logic [19:0] col_dhz
);

  // ==========================================================================
  // Row selection
  // ==========================================================================
  // Codes 1-3 and D share the first row, 0 and A-C the bottom row
  always_comb
  begin
    unique case (code)
      4'h1, 4'h2, 4'h3, 4'hd: row_dhz = tg_pkg::ROW0_DHZ;
      4'h4, 4'h5, 4'h6, 4'he: row_dhz = tg_pkg::ROW1_DHZ;
      4'h7, 4'h8, 4'h9, 4'hf: row_dhz = tg_pkg::ROW2_DHZ;
      4'hb, 4'ha, 4'hc, 4'h0: row_dhz = tg_pkg::ROW3_DHZ;
    endcase
  end

  // ==========================================================================
  // Column selection
  // ==========================================================================
  // Every code is legal, so no default branch is needed
  always_comb
  begin
    unique case (code)
      4'h1, 4'h4, 4'h7, 4'hb: col_dhz = tg_pkg::COL0_DHZ;
      4'h2, 4'h5, 4'h8, 4'ha: col_dhz = tg_pkg::COL1_DHZ;
      4'h3, 4'h6, 4'h9, 4'hc: col_dhz = tg_pkg::COL2_DHZ;
      4'hd, 4'he, 4'hf, 4'h0: col_dhz = tg_pkg::COL3_DHZ;
    endcase
  end

endmodule : tg_dtmf_map

//--- verilog/tg_tone_seq.sv
// Tone generator setup registers and burst/digit sequencer with AXI4-Lite access
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module tg_tone_seq #(
  parameter int MS_CYCLES = tg_pkg::MS_CYCLES // Cycles per millisecond
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tone_clk_en,
  output logic tone_a_on,
  output logic [19:0] tone_a_freq_dhz,
  output logic signed [8:0] tone_a_gain_hdb,
  output logic tone_b_on,
  output logic [19:0] tone_b_freq_dhz,
  output logic signed [8:0] tone_b_gain_hdb
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic aw_full_q; // Write address held
  logic [9:0] aw_idx_q; // Held write word index
  logic w_full_q; // Write data held
  logic [7:0] w_byte_q; // Held low byte of write data
  logic w_lane0_q; // Held strobe of byte lane 0
  logic wr_fire; // Both halves present, answer slot free
  logic wr_hit; // Write lands on a mapped register
  logic [31:0] rd_word; // Read mux result
  logic rd_hit; // Read lands on a mapped register
  logic go_q; // generate_go
  logic digit_mode_select_q; // One for digits, zero for bursts
  logic clk_en_q; // Tone clock enable
  logic [6:0] a_hi_q; // first_pitch_code bits 14:8
  logic [7:0] a_lo_q; // first_pitch_code bits 7:0
  logic [6:0] b_hi_q; // second_pitch_code bits 14:8
  logic [7:0] b_lo_q; // second_pitch_code bits 7:0
  logic [7:0] a_lvl_q; // first_loudness_code
  logic [7:0] b_lvl_q; // second_loudness_code
  logic [7:0] on_ms_q; // Present time
  logic [7:0] gap_ms_q; // Gap time
  logic [4:0] count_q; // Digit or burst count
  logic [7:0] bank_q [tg_pkg::DIGIT_PAIRS]; // Packed digit bank
  tg_pkg::tg_state_type state_q; // Sequencer state
  tg_pkg::tg_state_type state_d; // Next sequencer state
  logic [15:0] div_q; // Millisecond divider
  logic tick_ms; // One-cycle pulse per millisecond
  logic [7:0] ms_q; // Milliseconds spent in the phase
  logic restart; // Next phase begins in the following cycle
  logic [4:0] left_q; // Bursts still to finish
  logic [4:0] idx_q; // Current digit number
  logic done; // Run finished this cycle
  logic run; // Go and clock enable both set
  logic cont_cfg; // Continuous configuration
  logic [4:0] eff_count; // Count clamped to the maximum
  logic [3:0] digit_code; // Nibble of the current digit
  logic [7:0] digit_byte; // Byte holding the current digit
  logic [19:0] row_dhz; // Current digit row frequency
  logic [19:0] col_dhz; // Current digit column frequency
  logic [14:0] a_code; // Full pitch code A
  logic [14:0] b_code; // Full pitch code B
  logic sounding; // Phase in which tones are heard
  logic on_end; // Last cycle of a present phase
  logic gap_end; // Last cycle of a silent phase

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  // Address and data are caught separately so either may come first
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;

  // Holding register for the write address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      aw_idx_q <= 10'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      aw_idx_q <= s_axi_awaddr[11:2];
    end
    else if (wr_fire)
    begin
      aw_full_q <= 1'b0;
    end
  end

  // Holding register for the write data; only lane 0 carries bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q <= 1'b0;
      w_byte_q <= tg_pkg::BYTE_RST;
      w_lane0_q <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q <= 1'b1;
      w_byte_q <= s_axi_wdata[7:0];
      w_lane0_q <= s_axi_wstrb[0];
    end
    else if (wr_fire)
    begin
      w_full_q <= 1'b0;
    end
  end

  // Map check for writes; the status word is read only and refuses writes
  always_comb
  begin
    wr_hit = (aw_idx_q >= tg_pkg::IDX_CTRL && aw_idx_q <= tg_pkg::IDX_COUNT)
      || (aw_idx_q >= tg_pkg::IDX_DIGIT0
      && aw_idx_q < tg_pkg::IDX_DIGIT0 + 10'(tg_pkg::DIGIT_PAIRS));
  end

  // Write answer, one cycle after both halves are present
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tg_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? tg_pkg::RESP_OKAY : tg_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Control register
  // ==========================================================================
  // A software write wins over the self-clear landing in the same cycle,
  // so a fresh start is never swallowed by the end of the previous run
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      go_q <= 1'b0;
      digit_mode_select_q <= 1'b0;
      clk_en_q <= 1'b0;
    end
    else if (wr_fire && w_lane0_q && aw_idx_q == tg_pkg::IDX_CTRL)
    begin
      go_q <= w_byte_q[tg_pkg::CTRL_GO_BIT];
      digit_mode_select_q <= w_byte_q[tg_pkg::CTRL_DIGIT_BIT];
      clk_en_q <= w_byte_q[tg_pkg::CTRL_CLKEN_BIT];
    end
    else if (done)
    begin
      go_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Tone setup registers
  // ==========================================================================
  // Pitch codes are split high byte first at the lower index
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      a_hi_q <= tg_pkg::BYTE_RST[6:0];
      a_lo_q <= tg_pkg::BYTE_RST;
      b_hi_q <= tg_pkg::BYTE_RST[6:0];
      b_lo_q <= tg_pkg::BYTE_RST;
      a_lvl_q <= tg_pkg::BYTE_RST;
      b_lvl_q <= tg_pkg::BYTE_RST;
      on_ms_q <= tg_pkg::BYTE_RST;
      gap_ms_q <= tg_pkg::BYTE_RST;
      count_q <= tg_pkg::BYTE_RST[4:0];
    end
    else if (wr_fire && w_lane0_q)
    begin
      unique case (aw_idx_q)
        tg_pkg::IDX_A_HI: a_hi_q <= w_byte_q[6:0];
        tg_pkg::IDX_A_LO: a_lo_q <= w_byte_q;
        tg_pkg::IDX_B_HI: b_hi_q <= w_byte_q[6:0];
        tg_pkg::IDX_B_LO: b_lo_q <= w_byte_q;
        tg_pkg::IDX_A_LVL: a_lvl_q <= w_byte_q;
        tg_pkg::IDX_B_LVL: b_lvl_q <= w_byte_q;
        tg_pkg::IDX_ON_MS: on_ms_q <= w_byte_q;
        tg_pkg::IDX_GAP_MS: gap_ms_q <= w_byte_q;
        tg_pkg::IDX_COUNT: count_q <= w_byte_q[4:0];
        default: ; // Control, digits and unmapped handled elsewhere
      endcase
    end
  end

  // Digit bank, one generate entry per packed byte
  genvar gi;
  generate
    for (gi = 0; gi < tg_pkg::DIGIT_PAIRS; gi++)
    begin : g_bank
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          bank_q[gi] <= tg_pkg::BYTE_RST;
        end
        else if (wr_fire && w_lane0_q && aw_idx_q == tg_pkg::IDX_DIGIT0 + 10'(gi))
        begin
          bank_q[gi] <= w_byte_q;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  // Read data is registered; unused upper bits read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[11:2])
      tg_pkg::IDX_CTRL: rd_word = 32'({clk_en_q, 5'h00, digit_mode_select_q, go_q});
      tg_pkg::IDX_A_HI: rd_word = 32'(a_hi_q);
      tg_pkg::IDX_A_LO: rd_word = 32'(a_lo_q);
      tg_pkg::IDX_B_HI: rd_word = 32'(b_hi_q);
      tg_pkg::IDX_B_LO: rd_word = 32'(b_lo_q);
      tg_pkg::IDX_A_LVL: rd_word = 32'(a_lvl_q);
      tg_pkg::IDX_B_LVL: rd_word = 32'(b_lvl_q);
      tg_pkg::IDX_ON_MS: rd_word = 32'(on_ms_q);
      tg_pkg::IDX_GAP_MS: rd_word = 32'(gap_ms_q);
      tg_pkg::IDX_COUNT: rd_word = 32'(count_q);
      tg_pkg::IDX_STATUS: rd_word = 32'({left_q, idx_q, state_q});
      default:
      begin
        if (s_axi_araddr[11:2] >= tg_pkg::IDX_DIGIT0
          && s_axi_araddr[11:2] < tg_pkg::IDX_DIGIT0 + 10'(tg_pkg::DIGIT_PAIRS))
        begin
          rd_word = 32'(bank_q[4'(s_axi_araddr[11:2] - tg_pkg::IDX_DIGIT0)]);
        end
        else
        begin
          rd_hit = 1'b0; // Unmapped
        end
      end
    endcase
  end

  // One read at a time; the answer stands until rready
  assign s_axi_arready = !s_axi_rvalid;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tg_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? tg_pkg::RESP_OKAY : tg_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Millisecond timebase
  // ==========================================================================
  // Divider restarts with each phase so every phase but a zero present time is whole milliseconds
  assign tick_ms = (div_q == 16'(MS_CYCLES - 1));

  // Divider and phase millisecond counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || restart)
    begin
      div_q <= 16'h0000;
      ms_q <= 8'h00;
    end
    else if (tick_ms)
    begin
      div_q <= 16'h0000;
      ms_q <= ms_q + 8'h01;
    end
    else
    begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign run = go_q && clk_en_q;
  // All three timing fields zero marks endless generation
  assign cont_cfg = (on_ms_q == 8'h00) && (gap_ms_q == 8'h00) && (count_q == 5'h00);
  // Counts beyond the bank size are clamped rather than wrapping the index
  assign eff_count = (count_q > 5'(tg_pkg::MAX_COUNT)) ? 5'(tg_pkg::MAX_COUNT) : count_q;
  // Phases end on the last cycle of their final millisecond, so each lasts whole ms;
  // a zero present time still costs one cycle, the shortest phase possible
  assign on_end = (on_ms_q == 8'h00) || (tick_ms && (ms_q + 8'h01 == on_ms_q));
  assign gap_end = tick_ms && (ms_q + 8'h01 == gap_ms_q);

  // Next state, phase restart and completion
  always_comb
  begin
    state_d = state_q;
    restart = 1'b0;
    done = 1'b0;
    unique case (state_q)
      tg_pkg::ST_IDLE:
      begin
        restart = 1'b1;
        if (run && cont_cfg)
        begin
          state_d = tg_pkg::ST_CONT;
        end
        else if (run && eff_count == 5'h00)
        begin
          done = 1'b1; // Nothing to send
        end
        else if (run)
        begin
          state_d = tg_pkg::ST_ON;
        end
      end
      tg_pkg::ST_ON:
      begin
        if (!run)
        begin
          state_d = tg_pkg::ST_IDLE;
        end
        else if (on_end)
        begin
          restart = 1'b1;
          if (left_q == 5'h01)
          begin
            done = 1'b1;
            state_d = tg_pkg::ST_IDLE;
          end
          else if (gap_ms_q != 8'h00)
          begin
            state_d = tg_pkg::ST_GAP;
          end
          else
          begin
            state_d = tg_pkg::ST_ON;
          end
        end
      end
      tg_pkg::ST_GAP:
      begin
        if (!run)
        begin
          state_d = tg_pkg::ST_IDLE;
        end
        else if (gap_end)
        begin
          restart = 1'b1;
          state_d = tg_pkg::ST_ON;
        end
      end
      tg_pkg::ST_CONT:
      begin
        if (!run || !cont_cfg)
        begin
          state_d = tg_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_d = tg_pkg::ST_IDLE; // Recover from an illegal code
      end
    endcase
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= tg_pkg::ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Burst counting and digit index; the index advances as each burst but the last ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      left_q <= 5'h00;
      idx_q <= 5'h00;
    end
    else if (state_q == tg_pkg::ST_IDLE)
    begin
      left_q <= eff_count;
      idx_q <= 5'h00;
    end
    else if (state_q == tg_pkg::ST_ON && run && on_end && left_q != 5'h01)
    begin
      left_q <= left_q - 5'h01;
      idx_q <= idx_q + 5'h01;
    end
  end

  // ==========================================================================
  // Frequency and level outputs
  // ==========================================================================
  // Even digit in the high nibble, odd digit in the low nibble
  assign digit_byte = bank_q[idx_q[4:1]];
  assign digit_code = idx_q[0] ? digit_byte[3:0] : digit_byte[7:4];

  tg_dtmf_map i_tg_dtmf_map (
    .code(digit_code),
    .row_dhz(row_dhz),
    .col_dhz(col_dhz)
  );

  assign a_code = {a_hi_q, a_lo_q};
  assign b_code = {b_hi_q, b_lo_q};
  assign sounding = (state_q == tg_pkg::ST_ON) || (state_q == tg_pkg::ST_CONT);

  // Registered tone outputs; codes above the valid range are passed unchecked
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tone_clk_en <= 1'b0;
      tone_a_on <= 1'b0;
      tone_b_on <= 1'b0;
      tone_a_freq_dhz <= 20'h00000;
      tone_b_freq_dhz <= 20'h00000;
      tone_a_gain_hdb <= 9'sh000;
      tone_b_gain_hdb <= 9'sh000;
    end
    else
    begin
      tone_clk_en <= clk_en_q;
      tone_a_gain_hdb <= signed'({1'b0, a_lvl_q} - tg_pkg::LEVEL_ZERO_DB);
      tone_b_gain_hdb <= signed'({1'b0, b_lvl_q} - tg_pkg::LEVEL_ZERO_DB);
      if (digit_mode_select_q)
      begin
        tone_a_freq_dhz <= row_dhz;
        tone_b_freq_dhz <= col_dhz;
        tone_a_on <= sounding;
        tone_b_on <= sounding;
      end
      else
      begin
        tone_a_freq_dhz <= 20'(a_code * tg_pkg::PITCH_DHZ_STEP);
        tone_b_freq_dhz <= 20'(b_code * tg_pkg::PITCH_DHZ_STEP);
        tone_a_on <= sounding && (a_code != 15'h0000);
        tone_b_on <= sounding && (b_code != 15'h0000);
      end
    end
  end

endmodule : tg_tone_seq
